// File: psq_params.svh
`ifndef PSQ_PARAMS_SVH
`define PSQ_PARAMS_SVH
// Overview of operation
// - Four non-overlapping phases form one instruction cycle.
// - Counter advances entering first phase; fetch overlaps.
// - Sequential flow steps by one; jumps load.
// - Counter-changing instructions take two machine cycles.
// - Met skip discards fetched instruction; advance two.
// - Low byte writes jump within current page.
// - Reset and interrupts load fixed vectors.
// - Jump target bits plus bank select top bit.
// - Return stack holds counter values, software-invisible.
// - Call or interrupt acknowledge pushes counter.
// - Returns pop stack and restore counter.
// - Reset points stack index at top.
// - Full stack latches interrupt, withholds acknowledge.
// - Call on full stack still executes, overflows.
// - Eight-bit ALU computes results for named register.
// - ALU operations other than RR and RL update status flags.

`define PSQ_PC_W 14
`define PSQ_ADDR_W 13
`define PSQ_PAGE_W 8
`define PSQ_DATA_W 8
`define PSQ_STACK_DEPTH 8
`define PSQ_SP_W 4
`define PSQ_SP_STEP 4'h1
`define PSQ_PC_STEP 14'h0001
`define PSQ_NUM_INT 6
`define PSQ_VEC_RESET 14'h0000
`define PSQ_VEC_EXT0 14'h0004
`define PSQ_VEC_EXT1 14'h0008
`define PSQ_VEC_TMR0 14'h000c
`define PSQ_VEC_TMR1 14'h0010
`define PSQ_VEC_TMR2 14'h0014
`define PSQ_VEC_MULTI 14'h0018
`define PSQ_NIBBLE_W 4
`endif

// File: psq_pkg.sv
`include "psq_params.svh"
package psq_pkg;
  typedef enum logic [1:0] {
    PSQ_T1 = 2'h0,
    PSQ_T2 = 2'h1,
    PSQ_T3 = 2'h2,
    PSQ_T4 = 2'h3
  } psq_phase_e;

  typedef enum logic [2:0] {
    PSQ_OP_NONE = 3'h0,
    PSQ_OP_JUMP = 3'h1,
    PSQ_OP_CALL = 3'h2,
    PSQ_OP_RET = 3'h3,
    PSQ_OP_RETURN_FROM_INTERRUPT = 3'h4,
    PSQ_OP_SKIP = 3'h5,
    PSQ_OP_PCL = 3'h6
  } psq_op_e;

  typedef enum logic [3:0] {
    PSQ_ALU_ADD = 4'h0,
    PSQ_ALU_ADC = 4'h1,
    PSQ_ALU_SUB = 4'h2,
    PSQ_ALU_SBC = 4'h3,
    PSQ_ALU_AND = 4'h4,
    PSQ_ALU_OR = 4'h5,
    PSQ_ALU_XOR = 4'h6,
    PSQ_ALU_CPL = 4'h7,
    PSQ_ALU_RR = 4'h8,
    PSQ_ALU_RRC = 4'h9,
    PSQ_ALU_RL = 4'ha,
    PSQ_ALU_RLC = 4'hb,
    PSQ_ALU_INC = 4'hc,
    PSQ_ALU_DEC = 4'hd
  } psq_alu_op_e;

  typedef struct packed {
    psq_op_e op;
    logic [`PSQ_ADDR_W-1:0] target;
    logic [`PSQ_PAGE_W-1:0] pcl_data;
  } psq_cmd_s;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } psq_status_s;

  typedef logic [`PSQ_PC_W-1:0] psq_pc_t;
endpackage

// File: psq_alu.sv
`timescale 1ns/10ps
`include "psq_params.svh"
module psq_alu #(
  parameter int W = `PSQ_DATA_W
) (
  input logic clock,
  input logic rst,
  input logic go,
  input psq_pkg::psq_alu_op_e op,
  input logic [W-1:0] a,
  input logic [W-1:0] b,
  output logic [W-1:0] result,
  output psq_pkg::psq_status_s status,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] res;
    psq_pkg::psq_status_s st;
    logic done;
  } psq_alu_state_s;

  psq_alu_state_s s_r;
  psq_alu_state_s s_nxt;
  logic [W:0] sum;
  logic [`PSQ_NIBBLE_W:0] half;
  logic [W-1:0] bb;
  logic cin;
  logic [W-1:0] res;

  // -----------------------------------------------------------------
  // Result and flag computation.
  // -----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = go;
    bb = b;
    cin = 1'b0;
    if ((op == psq_pkg::PSQ_ALU_SUB) || (op == psq_pkg::PSQ_ALU_SBC)) begin
      bb = ~b;
    end
    if ((op == psq_pkg::PSQ_ALU_ADC) || (op == psq_pkg::PSQ_ALU_SBC)) begin
      cin = s_r.st.c;
    end else if (op == psq_pkg::PSQ_ALU_SUB) begin
      cin = 1'b1;
    end
    sum = {1'b0, a} + {1'b0, bb} + {{W{1'b0}}, cin};
    half = {1'b0, a[`PSQ_NIBBLE_W-1:0]} + {1'b0, bb[`PSQ_NIBBLE_W-1:0]}
         + {{`PSQ_NIBBLE_W{1'b0}}, cin};
    case (op)
      psq_pkg::PSQ_ALU_AND: res = a & b;
      psq_pkg::PSQ_ALU_OR: res = a | b;
      psq_pkg::PSQ_ALU_XOR: res = a ^ b;
      psq_pkg::PSQ_ALU_CPL: res = ~a;
      psq_pkg::PSQ_ALU_RR: res = {a[0], a[W-1:1]};
      psq_pkg::PSQ_ALU_RRC: res = {s_r.st.c, a[W-1:1]};
      psq_pkg::PSQ_ALU_RL: res = {a[W-2:0], a[W-1]};
      psq_pkg::PSQ_ALU_RLC: res = {a[W-2:0], s_r.st.c};
      psq_pkg::PSQ_ALU_INC: res = a + {{(W-1){1'b0}}, 1'b1};
      psq_pkg::PSQ_ALU_DEC: res = a - {{(W-1){1'b0}}, 1'b1};
      default: res = sum[W-1:0];
    endcase
    if (go) begin
      s_nxt.res = res;
      case (op)
        psq_pkg::PSQ_ALU_ADD, psq_pkg::PSQ_ALU_ADC,
        psq_pkg::PSQ_ALU_SUB, psq_pkg::PSQ_ALU_SBC: begin
          s_nxt.st.c = sum[W];
          s_nxt.st.ac = half[`PSQ_NIBBLE_W];
          s_nxt.st.ov = (a[W-1] == bb[W-1]) && (sum[W-1] != a[W-1]);
          s_nxt.st.z = (res == '0);
        end
        psq_pkg::PSQ_ALU_RRC: s_nxt.st.c = a[0];
        psq_pkg::PSQ_ALU_RLC: s_nxt.st.c = a[W-1];
        psq_pkg::PSQ_ALU_RR, psq_pkg::PSQ_ALU_RL: s_nxt.st = s_r.st;
        default: s_nxt.st.z = (res == '0);
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign result = s_r.res;
  assign status = s_r.st;
  assign done = s_r.done;

  // -----------------------------------------------------------------
  // Checks.
  // -----------------------------------------------------------------
  chk_alu_zero_flag: assert property (@(posedge clock) disable iff (rst)
    go && (op == psq_pkg::PSQ_ALU_XOR) |=> status.z == (result == '0))
    else $error("ALU zero flag does not follow result");
  chk_alu_add_result: assert property (@(posedge clock) disable iff (rst)
    go && (op == psq_pkg::PSQ_ALU_ADD) |=> {status.c, result} == $past(a) + $past(b))
    else $error("ALU sum or carry wrong");
endmodule

// File: psq_core.sv
`timescale 1ns/10ps
`include "psq_params.svh"
module psq_core #(
  parameter int DEPTH = `PSQ_STACK_DEPTH,
  parameter int NINT = `PSQ_NUM_INT
) (
  input logic clock,
  input logic rst,
  input logic cmd_valid,
  input psq_pkg::psq_cmd_s cmd,
  input logic skip_cond,
  input logic bank_select_bit,
  input logic int_enable,
  input logic [NINT-1:0] int_req,
  input logic alu_go,
  input psq_pkg::psq_alu_op_e alu_op,
  input logic [`PSQ_DATA_W-1:0] alu_a,
  input logic [`PSQ_DATA_W-1:0] alu_b,
  output logic [3:0] phase_clocks,
  output psq_pkg::psq_pc_t fetch_addr,
  output logic [`PSQ_PAGE_W-1:0] counter_low_byte,
  output logic discard,
  output logic int_ack,
  output logic [NINT-1:0] int_pending,
  output logic stack_full,
  output logic stack_overflow,
  output logic [`PSQ_DATA_W-1:0] alu_result,
  output psq_pkg::psq_status_s alu_status,
  output logic alu_done
);
  typedef struct packed {
    psq_pkg::psq_phase_e phase;
    logic [3:0] phase_clk;
    psq_pkg::psq_pc_t pc;
    logic [DEPTH-1:0][`PSQ_PC_W-1:0] stk;
    logic [`PSQ_SP_W-1:0] sp;
    logic [NINT-1:0] pend;
    logic dummy;
    logic ack;
    logic full;
    logic ovf;
  } psq_core_state_s;

  psq_core_state_s s_r;
  psq_core_state_s s_nxt;
  psq_pkg::psq_op_e op_eff;
  logic t4;
  logic take_int;
  logic [NINT-1:0] clr;
  logic [`PSQ_SP_W-1:0] idx;

  // -----------------------------------------------------------------
  // Helper functions.
  // -----------------------------------------------------------------
  function automatic psq_pkg::psq_pc_t vec_of(input logic [NINT-1:0] pend);
    psq_pkg::psq_pc_t v;
    v = `PSQ_VEC_RESET;
    if (pend[0]) begin
      v = `PSQ_VEC_EXT0;
    end else if (pend[1]) begin
      v = `PSQ_VEC_EXT1;
    end else if (pend[2]) begin
      v = `PSQ_VEC_TMR0;
    end else if (pend[3]) begin
      v = `PSQ_VEC_TMR1;
    end else if (pend[4]) begin
      v = `PSQ_VEC_TMR2;
    end else if (pend[5]) begin
      v = `PSQ_VEC_MULTI;
    end
    return v;
  endfunction

  // Lowest set bit only, so one source is acknowledged at a time.
  function automatic logic [NINT-1:0] lowest(input logic [NINT-1:0] p);
    return p & (~p + {{(NINT-1){1'b0}}, 1'b1});
  endfunction

  function automatic logic [3:0] phase_onehot(input psq_pkg::psq_phase_e ph);
    return 4'h1 << ph;
  endfunction

  // -----------------------------------------------------------------
  // Sequencing.
  // -----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    clr = '0;
    idx = s_r.sp;
    t4 = (s_r.phase == psq_pkg::PSQ_T4);
    op_eff = psq_pkg::PSQ_OP_NONE;
    if (cmd_valid && !s_r.dummy) begin
      op_eff = cmd.op;
    end
    take_int = 1'b0;
    case (s_r.phase)
      psq_pkg::PSQ_T1: s_nxt.phase = psq_pkg::PSQ_T2;
      psq_pkg::PSQ_T2: s_nxt.phase = psq_pkg::PSQ_T3;
      psq_pkg::PSQ_T3: s_nxt.phase = psq_pkg::PSQ_T4;
      psq_pkg::PSQ_T4: s_nxt.phase = psq_pkg::PSQ_T1;
      default: s_nxt.phase = psq_pkg::PSQ_T1;
    endcase
    s_nxt.phase_clk = phase_onehot(s_nxt.phase);
    if (t4) begin
      // The counter moves only on the edge that opens the first phase.
      s_nxt.dummy = 1'b0;
      case (op_eff)
        psq_pkg::PSQ_OP_JUMP: begin
          s_nxt.pc = {bank_select_bit, cmd.target};
          s_nxt.dummy = 1'b1;
        end
        psq_pkg::PSQ_OP_CALL: begin
          // A full stack still takes the call and wraps over the oldest level.
          if (s_r.sp < DEPTH[`PSQ_SP_W-1:0]) begin
            s_nxt.stk[s_r.sp[`PSQ_SP_W-2:0]] = s_r.pc;
            s_nxt.sp = s_r.sp + `PSQ_SP_STEP;
          end else begin
            s_nxt.stk[0] = s_r.pc;
            s_nxt.ovf = 1'b1;
          end
          s_nxt.pc = {bank_select_bit, cmd.target};
          s_nxt.dummy = 1'b1;
        end
        psq_pkg::PSQ_OP_RET, psq_pkg::PSQ_OP_RETURN_FROM_INTERRUPT: begin
          if (s_r.sp != '0) begin
            idx = s_r.sp - `PSQ_SP_STEP;
            s_nxt.sp = idx;
          end
          s_nxt.pc = s_r.stk[idx[`PSQ_SP_W-2:0]];
          s_nxt.dummy = 1'b1;
        end
        psq_pkg::PSQ_OP_SKIP: begin
          s_nxt.pc = s_r.pc + `PSQ_PC_STEP;
          s_nxt.dummy = skip_cond;
        end
        psq_pkg::PSQ_OP_PCL: begin
          s_nxt.pc = {s_r.pc[`PSQ_PC_W-1:`PSQ_PAGE_W], cmd.pcl_data};
          s_nxt.dummy = 1'b1;
        end
        default: begin
          // Requests wait while the stack is full; a return frees a level.
          take_int = int_enable && (s_r.pend != '0) && !s_r.full;
          if (take_int) begin
            s_nxt.stk[s_r.sp[`PSQ_SP_W-2:0]] = s_r.pc;
            s_nxt.sp = s_r.sp + `PSQ_SP_STEP;
            s_nxt.pc = vec_of(s_r.pend);
            clr = lowest(s_r.pend);
            s_nxt.ack = 1'b1;
            s_nxt.dummy = 1'b1;
          end else begin
            s_nxt.pc = s_r.pc + `PSQ_PC_STEP;
          end
        end
      endcase
    end
    s_nxt.pend = (s_r.pend & ~clr) | int_req;
    s_nxt.full = (s_nxt.sp == DEPTH[`PSQ_SP_W-1:0]);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
      s_r.pc <= `PSQ_VEC_RESET;
      s_r.phase <= psq_pkg::PSQ_T1;
      s_r.phase_clk <= 4'h1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Arithmetic unit.
  // -----------------------------------------------------------------
  psq_alu #(
    .W(`PSQ_DATA_W)
  ) u_alu (
    .clock(clock),
    .rst(rst),
    .go(alu_go),
    .op(alu_op),
    .a(alu_a),
    .b(alu_b),
    .result(alu_result),
    .status(alu_status),
    .done(alu_done)
  );

  // The stack has no software path; only the full and overflow flags leave.
  assign phase_clocks = s_r.phase_clk;
  assign fetch_addr = s_r.pc;
  assign counter_low_byte = s_r.pc[`PSQ_PAGE_W-1:0];
  assign discard = s_r.dummy;
  assign int_ack = s_r.ack;
  assign int_pending = s_r.pend;
  assign stack_full = s_r.full;
  assign stack_overflow = s_r.ovf;

  // -----------------------------------------------------------------
  // Checks.
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  chk_phase_onehot: assert property ($onehot(phase_clocks))
    else $error("Phase clocks not one-hot");
  chk_phase_order: assert property (phase_clocks[0] && !rst |=> phase_clocks[1] ##1
    phase_clocks[2] ##1 phase_clocks[3] ##1 phase_clocks[0])
    else $error("Phase order broken");
  chk_pc_at_t1: assert property ($changed(fetch_addr) |-> phase_clocks[0])
    else $error("Counter moved outside first phase");
  chk_seq_step: assert property (t4 && (op_eff == psq_pkg::PSQ_OP_NONE) && !take_int
    |=> fetch_addr == $past(fetch_addr) + `PSQ_PC_STEP && !discard)
    else $error("Sequential step wrong");
  chk_jump_target: assert property (t4 && (op_eff == psq_pkg::PSQ_OP_JUMP)
    |=> fetch_addr == {$past(bank_select_bit), $past(cmd.target)})
    else $error("Jump target wrong");
  chk_branch_dummy: assert property (t4 && (op_eff == psq_pkg::PSQ_OP_CALL)
    |=> discard [*4] ##1 (!discard || int_ack))
    else $error("Branch did not take exactly one dummy cycle");
  chk_skip_dummy: assert property (t4 && (op_eff == psq_pkg::PSQ_OP_SKIP) && skip_cond
    |=> discard && fetch_addr == $past(fetch_addr) + `PSQ_PC_STEP)
    else $error("Skip handling wrong");
  chk_pcl_page: assert property (t4 && (op_eff == psq_pkg::PSQ_OP_PCL)
    |=> fetch_addr[13:8] == $past(fetch_addr[13:8]) && counter_low_byte == $past(cmd.pcl_data))
    else $error("Low byte write left page");
  chk_int_vector: assert property (int_ack |-> fetch_addr[13:5] == '0
    && fetch_addr[1:0] == '0 && fetch_addr != `PSQ_VEC_RESET && discard)
    else $error("Interrupt vector wrong");
  chk_call_push: assert property (t4 && (op_eff == psq_pkg::PSQ_OP_CALL) && !stack_full
    |=> s_r.sp == $past(s_r.sp) + `PSQ_SP_STEP)
    else $error("Call did not push");
  chk_ret_restore: assert property (t4 && (op_eff == psq_pkg::PSQ_OP_RET) && s_r.sp != '0
    |=> fetch_addr == $past(s_r.stk[s_r.sp[2:0] - 3'h1]))
    else $error("Return restored wrong value");
  chk_reset_index: assert property ($fell(rst) |-> s_r.sp == '0
    && fetch_addr == `PSQ_VEC_RESET)
    else $error("Reset state wrong");
  chk_full_holdoff: assert property (stack_full && t4 |=> !int_ack)
    else $error("Acknowledge given on full stack");
  chk_call_overflow: assert property (t4 && (op_eff == psq_pkg::PSQ_OP_CALL) && stack_full
    |=> stack_overflow && discard)
    else $error("Call on full stack not executed");

  // -----------------------------------------------------------------
  // Dummy-cycle, skip, stack and interrupt checks.
  // -----------------------------------------------------------------
  chk_jump_dummy: assert property (t4 && (op_eff == psq_pkg::PSQ_OP_JUMP)
    |=> discard)
    else $error("Jump did not insert a dummy cycle");
  chk_pcl_dummy: assert property (t4 && (op_eff == psq_pkg::PSQ_OP_PCL)
    |=> discard)
    else $error("Low byte write did not insert a dummy cycle");
  chk_skip_plain: assert property (t4 && (op_eff == psq_pkg::PSQ_OP_SKIP)
    && !skip_cond |=> !discard && fetch_addr == $past(fetch_addr) + `PSQ_PC_STEP)
    else $error("Unmet skip changed the flow");
  chk_return_from_interrupt_restore: assert property (t4 && (op_eff == psq_pkg::PSQ_OP_RETURN_FROM_INTERRUPT)
    && s_r.sp != '0 |=> fetch_addr == $past(s_r.stk[s_r.sp[2:0] - 3'h1]))
    else $error("Interrupt return restored wrong value");
  chk_full_level: assert property (t4 && (op_eff == psq_pkg::PSQ_OP_CALL)
    && (s_r.sp + `PSQ_SP_STEP) == DEPTH[`PSQ_SP_W-1:0] |=> stack_full)
    else $error("Stack not full after last free level used");
  chk_int_push: assert property (t4 && take_int
    |=> int_ack && s_r.sp == $past(s_r.sp) + `PSQ_SP_STEP
    && s_r.stk[$past(s_r.sp[2:0])] == $past(fetch_addr))
    else $error("Interrupt did not push the counter");
  chk_int_clear: assert property (t4 && take_int
    |=> int_pending == (($past(int_pending) & ~lowest($past(int_pending))) | $past(int_req)))
    else $error("Acknowledged request not cleared");
  chk_pend_latch: assert property (int_req != '0
    |=> (int_pending & $past(int_req)) == $past(int_req))
    else $error("Request not latched");
  chk_ovf_sticky: assert property (stack_overflow |=> stack_overflow)
    else $error("Overflow flag dropped");
  chk_ack_pulse: assert property (int_ack |=> !int_ack)
    else $error("Acknowledge longer than one clock");

  cov_int_taken: cover property (int_ack);
  cov_full_then_ret: cover property (stack_full ##[1:64] (t4 && op_eff == psq_pkg::PSQ_OP_RETURN_FROM_INTERRUPT));
  cov_overflow: cover property ($rose(stack_overflow));
  cov_skip_taken: cover property (t4 && op_eff == psq_pkg::PSQ_OP_SKIP && skip_cond);
  cov_pcl_write: cover property (t4 && op_eff == psq_pkg::PSQ_OP_PCL);
endmodule

// File: psq_far_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Interrupt request side of the sequencer
// ----------------------------------------------------------------------
// Sends one request pulse on the chosen source when asked to. A prompt
// answer pulses on the edge after the ask; a slow one waits one clock more.
module psq_far_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic fire,
  input wire logic slow,
  input wire logic [2:0] src,
  output logic [5:0] int_req
);
  logic hold_r;
  logic [2:0] src_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      int_req <= 6'h00;
      hold_r <= 1'b0;
      src_r <= 3'h0;
    end else begin
      int_req <= 6'h00;
      hold_r <= fire && slow;
      src_r <= src;
      if (fire && !slow) begin
        int_req[src] <= 1'b1;
      end
      if (hold_r) begin
        int_req[src_r] <= 1'b1;
      end
    end
  end
endmodule

// File: tb.sv
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic [13:0] pc;
    logic disc;
    logic ack;
    logic full;
    logic ovf;
    logic [5:0] pend;
  } psq_exp_s;
  typedef struct packed {
    logic [7:0] r;
    psq_pkg::psq_status_s st;
  } psq_aexp_s;
  localparam psq_pkg::psq_op_e K_NONE = psq_pkg::PSQ_OP_NONE;
  localparam psq_pkg::psq_op_e K_JUMP = psq_pkg::PSQ_OP_JUMP;
  localparam psq_pkg::psq_op_e K_CALL = psq_pkg::PSQ_OP_CALL;
  localparam psq_pkg::psq_op_e K_RET = psq_pkg::PSQ_OP_RET;
  localparam psq_pkg::psq_op_e K_RETURN_FROM_INTERRUPT = psq_pkg::PSQ_OP_RETURN_FROM_INTERRUPT;
  localparam psq_pkg::psq_op_e K_SKIP = psq_pkg::PSQ_OP_SKIP;
  localparam psq_pkg::psq_op_e K_PCL = psq_pkg::PSQ_OP_PCL;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  psq_pkg::psq_cmd_s cmd = '0;
  logic skip_cond = 1'b0;
  logic bank_select_bit = 1'b0;
  logic int_enable = 1'b0;
  logic [5:0] int_req;
  logic alu_go = 1'b0;
  psq_pkg::psq_alu_op_e alu_op = psq_pkg::PSQ_ALU_ADD;
  logic [7:0] alu_a = 8'h00;
  logic [7:0] alu_b = 8'h00;
  logic [3:0] phase_clocks;
  psq_pkg::psq_pc_t fetch_addr;
  logic [7:0] counter_low_byte;
  logic discard, int_ack, stack_full, stack_overflow, alu_done;
  logic [5:0] int_pending;
  logic [7:0] alu_result;
  psq_pkg::psq_status_s alu_status, ast;
  logic fire = 1'b0;
  logic slow = 1'b0;
  logic [2:0] src = 3'h0;
  logic [31:0] seed = 32'h0000e4f5;
  logic [13:0] pc;
  logic [13:0] stk [8];
  logic [3:0] sp;
  logic [5:0] pend;
  logic disc, ovf, ien;
  logic [3:0] prevph = 4'h0;
  int bad_count = 0;
  int compares = 0;
  psq_exp_s q[$];
  psq_aexp_s aq[$];

  psq_core i_dut (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .skip_cond(skip_cond), .bank_select_bit(bank_select_bit), .int_enable(int_enable),
    .int_req(int_req), .alu_go(alu_go), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
    .phase_clocks(phase_clocks), .fetch_addr(fetch_addr), .counter_low_byte(counter_low_byte),
    .discard(discard), .int_ack(int_ack), .int_pending(int_pending), .stack_full(stack_full),
    .stack_overflow(stack_overflow), .alu_result(alu_result), .alu_status(alu_status),
    .alu_done(alu_done));

  psq_far_model i_far (.clock(clock), .rst(rst), .fire(fire), .slow(slow), .src(src),
    .int_req(int_req));

  initial begin
    forever #20 clock = ~clock;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(logic [31:0] seen, logic [31:0] exp, string what);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Reference result of one ALU operation; rotates and logic keep other flags.
  function automatic psq_aexp_s aref(logic [3:0] op, logic [7:0] a, logic [7:0] b,
                                     psq_pkg::psq_status_s s);
    logic [8:0] sum;
    logic [4:0] hs;
    logic [7:0] x;
    logic cin;
    psq_aexp_s e;
    e.st = s;
    x = op[1] ? ~b : b;
    cin = op[0] ? s.c : op[1];
    sum = {1'b0, a} + {1'b0, x} + {8'h00, cin};
    hs = {1'b0, a[3:0]} + {1'b0, x[3:0]} + {4'h0, cin};
    case (op)
      4'h4: e.r = a & b;
      4'h5: e.r = a | b;
      4'h6: e.r = a ^ b;
      4'h7: e.r = ~a;
      4'h8: e.r = {a[0], a[7:1]};
      4'h9: e.r = {s.c, a[7:1]};
      4'ha: e.r = {a[6:0], a[7]};
      4'hb: e.r = {a[6:0], s.c};
      4'hc: e.r = a + 8'h01;
      4'hd: e.r = a - 8'h01;
      default: e.r = sum[7:0];
    endcase
    if (op < 4'h4) begin
      e.st.c = sum[8];
      e.st.ac = hs[4];
      e.st.ov = (a[7] == x[7]) && (e.r[7] != a[7]);
    end
    if (op == 4'h9 || op == 4'hb) begin
      e.st.c = (op == 4'h9) ? a[0] : a[7];
    end
    if (op < 4'h8 || op > 4'hb) begin
      e.st.z = (e.r == 8'h00);
    end
    return e;
  endfunction

  task automatic do_reset();
    repeat (2) @(posedge clock);
    rst <= 1'b1;
    repeat (10) @(posedge clock);
    q.delete();
    pc = 14'h0000;
    sp = 4'h0;
    pend = 6'h00;
    disc = 1'b0;
    ovf = 1'b0;
    rst <= 1'b0;
    @(negedge clock);
    chk(phase_clocks, 4'h1, "reset phase");
    chk(fetch_addr, 14'h0000, "reset vector");
    chk(stack_full, 1'b0, "reset stack");
    chk(stack_overflow, 1'b0, "reset overflow");
  endtask

  // One instruction cycle: optional request at T2, command held through T4.
  task automatic instr(psq_pkg::psq_op_e op, logic [12:0] tgt = '0, logic [7:0] dat = '0,
                       logic skp = 1'b0, int f = -1, logic sl = 1'b0);
    logic [31:0] r;
    logic vld;
    int k;
    psq_exp_s e;
    r = rnd();
    while (phase_clocks !== 4'h1) @(negedge clock);
    @(posedge clock);
    fire <= (f >= 0);
    src <= f[2:0];
    slow <= sl;
    @(posedge clock);
    fire <= 1'b0;
    @(posedge clock);
    vld = (op != K_NONE) || (pend == 6'h00 && f < 0 && r[1]);
    cmd_valid <= vld;
    cmd <= '{op: (vld ? op : K_JUMP), target: tgt, pcl_data: dat};
    skip_cond <= skp;
    bank_select_bit <= r[0];
    int_enable <= ien;
    if (f >= 0 && !sl) pend[f] = 1'b1;
    e.ack = ien && pend != 6'h00 && sp < 4'h8 && (disc || op == K_NONE);
    if (e.ack) begin
      for (k = 0; k < 5 && !pend[k]; k++) begin
      end
      pend[k] = 1'b0;
      stk[sp[2:0]] = pc;
      sp++;
      pc = 14'((k + 1) * 4);
      disc = 1'b1;
    end else if (disc || !vld || op == K_NONE) begin
      pc++;
      disc = 1'b0;
    end else begin
      case (op)
        K_JUMP: pc = {r[0], tgt};
        K_CALL: begin
          if (sp == 4'h8) begin
            stk[0] = pc;
            ovf = 1'b1;
          end else begin
            stk[sp[2:0]] = pc;
            sp++;
          end
          pc = {r[0], tgt};
        end
        K_RET, K_RETURN_FROM_INTERRUPT: begin
          if (sp != 4'h0) sp--;
          pc = stk[sp[2:0]];
        end
        K_SKIP: pc++;
        default: pc = {pc[13:8], dat};
      endcase
      disc = (op != K_SKIP) || skp;
    end
    if (f >= 0 && sl) pend[f] = 1'b1;
    e.pc = pc;
    e.disc = disc;
    e.full = (sp == 4'h8);
    e.ovf = ovf;
    e.pend = pend;
    q.push_back(e);
  endtask

  // ----------------------------------------------------------------------
  // Output watcher
  // ----------------------------------------------------------------------
  initial begin
    psq_exp_s e;
    psq_aexp_s a;
    forever begin
      @(negedge clock);
      if (!rst && !(prevph === 4'h1 && phase_clocks === 4'h1) && prevph !== 4'h0) begin
        chk(phase_clocks, {prevph[2:0], prevph[3]}, "phase");
      end
      if (!rst && phase_clocks === 4'h1 && prevph === 4'h8 && q.size() > 0) begin
        e = q.pop_front();
        chk(fetch_addr, e.pc, "counter");
        chk(counter_low_byte, e.pc[7:0], "low byte");
        chk(discard, e.disc, "dummy");
        chk(int_ack, e.ack, "ack");
        chk(stack_full, e.full, "full");
        chk(stack_overflow, e.ovf, "overflow");
        chk(int_pending, e.pend, "pending");
      end
      if (alu_done === 1'b1 && aq.size() > 0) begin
        a = aq.pop_front();
        chk(alu_result, a.r, "alu result");
        chk(alu_status, a.st, "alu status");
      end
      prevph = phase_clocks;
    end
  end

  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    test_done();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] r;
    int i;
    ien = 1'b1;
    ast = '0;
    do_reset();
    fork
      begin
        instr(K_CALL, 13'(rnd()));
        instr(K_JUMP, 13'(rnd()));
        for (i = 1; i < 8; i++) begin
          instr(K_CALL, 13'(rnd()));
          instr(K_NONE);
        end
        instr(K_NONE, '0, '0, 1'b0, 0);
        instr(K_CALL, 13'(rnd()));
        instr(K_NONE);
        instr(K_RET);
        instr(K_NONE);
        instr(K_NONE);
        repeat (8) begin
          instr(K_RETURN_FROM_INTERRUPT);
          instr(K_NONE);
        end
      end
      begin
        for (int j = 0; j < 28; j++) begin
          r = rnd();
          @(posedge clock);
          alu_go <= 1'b1;
          alu_op <= psq_pkg::psq_alu_op_e'(4'(j % 14));
          alu_a <= r[7:0];
          alu_b <= r[15:8];
          aq.push_back(aref(4'(j % 14), r[7:0], r[15:8], ast));
          ast = aq[$].st;
          if (r[16]) begin
            @(posedge clock);
            alu_go <= 1'b0;
          end
        end
        @(posedge clock);
        alu_go <= 1'b0;
      end
    join
    do_reset();
    repeat (3) instr(K_NONE);
    repeat (4) begin
      instr(K_JUMP, 13'(rnd()));
      instr(K_NONE);
    end
    instr(K_SKIP, '0, '0, 1'b1);
    instr(K_NONE);
    instr(K_SKIP);
    instr(K_PCL, '0, 8'(rnd()));
    instr(K_NONE);
    ien = 1'b0;
    instr(K_NONE, '0, '0, 1'b0, 5, 1'b1);
    instr(K_NONE);
    ien = 1'b1;
    for (i = 0; i < 6; i++) instr(K_NONE, '0, '0, 1'b0, i, i[0]);
    repeat (3) instr(K_NONE);
    repeat (6) begin
      instr(K_RETURN_FROM_INTERRUPT);
      instr(K_NONE);
    end
    instr(K_NONE);
    repeat (8) @(posedge clock);
    chk(q.size(), 0, "pending results");
    chk(aq.size(), 0, "alu results");
    test_done();
  end
endmodule
